// >>> src/cfg_ident_regs.sv
`timescale 1ns/1ps
`include "cfg_ident_map.svh"

// What this block does
// - revision byte at 08h, read only, value chosen per design.
// - 24-bit read-only class code at 09h, three byte fields.
// - base class byte always reads 0ch, serial bus controller.
// - sub-class byte always reads 03h, usb host controller.
// - programming interface 10h for full-speed functions, 20h for high-speed.
// - cache line size at 0ch, read/write, counted in dwords.
// - cache line size clears to 00h on bus reset.
// - as master, cache line size picks plain, line or multiple read.
// - as target, cache line size detects where a burst wraps.
// - latency timer byte, read/write, pci clocks, resets to 00h.
// - header type bit 7 reads 1, several functions present.
// - header type bits 6 to 0 read zero.
module cfg_ident_regs #(
    parameter cfg_ident_pkg::func_kind_e FUNC_KIND    = cfg_ident_pkg::FN_OPEN_FS_A,
    parameter logic [7:0]                DESIGN_REV   = 8'h01,  // arbitrary value
    parameter int                        ADDR_W       = 8
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire cfg_ident_pkg::cfg_req_s cfg_req,
    output logic                         cfg_ack,
    output logic [31:0]                  cfg_rdata,
    output logic [7:0]                   cache_line_words,
    output logic [7:0]                   bus_master_tenure_count,
    input  wire logic [7:0]              mst_read_dwords,
    output logic [3:0]                   mst_read_cmd,
    input  wire logic                    tgt_burst_active,
    input  wire logic [ADDR_W-1:0]       tgt_dw_addr,
    output logic                         burst_wrap,
    input  wire logic                    mst_frame,
    output logic                         tenure_expired
);

    ////////////////////////////////////////////////////////////////////////
    // fixed identity bytes

    logic [7:0]  programming_interface_code;
    logic [7:0]  design_revision_byte;
    logic [7:0]  base_class_byte;
    logic [7:0]  sub_class_byte;
    logic [7:0]  header_layout_code;
    logic        several_functions_flag;
    logic [23:0] function_class_code;
    logic [31:0] ident_word;
    logic        line_end;

    // interface byte follows the function kind
    assign programming_interface_code = (FUNC_KIND == cfg_ident_pkg::FN_ENHANCED_HS)
                                        ? `PI_ENHANCED_HS : `PI_OPEN_FS;
    assign design_revision_byte       = DESIGN_REV;
    assign base_class_byte            = `BASE_CLASS;
    assign sub_class_byte             = `SUB_CLASS;
    assign header_layout_code         = `HEADER_LAYOUT;
    assign several_functions_flag     = header_layout_code[7];
    assign function_class_code        = {base_class_byte, sub_class_byte,
                                         programming_interface_code};
    assign ident_word                 = {function_class_code, design_revision_byte};

    ////////////////////////////////////////////////////////////////////////
    // target burst wrap detection

    cache_line_wrap #(
        .AW               (ADDR_W)
    ) u_wrap (
        .cache_line_words (cache_line_words),
        .dw_addr          (tgt_dw_addr),
        .at_line_end      (line_end)
    );

    ////////////////////////////////////////////////////////////////////////
    // state update

    cfg_ident_pkg::regs_s r;
    cfg_ident_pkg::regs_s n;
    logic                 rd;
    logic                 wr;

    assign rd = cfg_req.sel && !cfg_req.wr;
    assign wr = cfg_req.sel && cfg_req.wr;

    // one access per cycle, answered one cycle later
    always_comb begin
        n       = r;
        n.ack   = cfg_req.sel;
        n.rdata = `WORD_ZERO;
        // read path, other header dwords read as zero here
        if (rd) begin
            case (cfg_req.dw_idx)
                `DW_IDENT: n.rdata = ident_word;
                `DW_LINE:  n.rdata = {`SELF_TEST_BYTE, several_functions_flag,
                                      header_layout_code[6:0],
                                      r.tenure, r.cache_line};
                default:   n.rdata = `WORD_ZERO;
            endcase
        end
        // only the two writable bytes take data; identity bytes ignore it
        if (wr && cfg_req.dw_idx == `DW_LINE) begin
            if (cfg_req.be[`LANE_CACHE_LINE]) begin
                n.cache_line = cfg_req.wdata[7:0];
            end
            if (cfg_req.be[`LANE_TENURE]) begin
                n.tenure = cfg_req.wdata[15:8];
            end
        end
        // read command choice; unknown line size means plain reads
        if (r.cache_line == 8'h00 || mst_read_dwords <= 8'h01) begin
            n.rd_cmd = `CMD_MEM_READ;
        end else if (mst_read_dwords <= r.cache_line) begin
            n.rd_cmd = `CMD_READ_LINE;
        end else begin
            n.rd_cmd = `CMD_READ_MULT;
        end
        n.wrap    = tgt_burst_active && line_end;
        // tenure countdown loads at frame start, counts pci clocks
        n.frame_q = mst_frame;
        if (mst_frame && !r.frame_q) begin
            n.tenure_left    = r.tenure;
            n.tenure_expired = 1'b0;
        end else if (mst_frame) begin
            if (r.tenure_left != 8'h00) begin
                n.tenure_left = r.tenure_left - 8'h01;
            end
            n.tenure_expired = (r.tenure_left == 8'h00);
        end else begin
            n.tenure_expired = 1'b0;
        end
    end

    // bus reset clears everything to constants
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r                <= '0;
            r.cache_line     <= `CACHE_LINE_RST;
            r.tenure         <= `TENURE_RST;
            r.rd_cmd         <= `CMD_MEM_READ;
        end else begin
            r <= n;
        end
    end

    assign cfg_ack                 = r.ack;
    assign cfg_rdata               = r.rdata;
    assign cache_line_words        = r.cache_line;
    assign bus_master_tenure_count = r.tenure;
    assign mst_read_cmd            = r.rd_cmd;
    assign burst_wrap              = r.wrap;
    assign tenure_expired          = r.tenure_expired;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_wr_ident;
        cfg_req.sel && cfg_req.wr && cfg_req.dw_idx == `DW_IDENT;
    endsequence

    sequence s_rd_ident;
        cfg_req.sel && !cfg_req.wr && cfg_req.dw_idx == `DW_IDENT;
    endsequence

    sequence s_rd_line;
        cfg_req.sel && !cfg_req.wr && cfg_req.dw_idx == `DW_LINE;
    endsequence

    property p_ident_read;
        s_rd_ident |=> cfg_ack && cfg_rdata[7:0] == DESIGN_REV;
    endproperty
    a_ident_read: assert property (p_ident_read) else $error("revision byte wrong");

    property p_class_bytes;
        s_rd_ident |=> cfg_rdata[31:24] == `BASE_CLASS && cfg_rdata[23:16] == `SUB_CLASS;
    endproperty
    a_class_bytes: assert property (p_class_bytes) else $error("class bytes wrong");

    property p_prog_if;
        s_rd_ident |=> cfg_rdata[15:8] == ((FUNC_KIND == cfg_ident_pkg::FN_ENHANCED_HS)
                                           ? `PI_ENHANCED_HS : `PI_OPEN_FS);
    endproperty
    a_prog_if: assert property (p_prog_if) else $error("interface byte wrong");

    property p_ident_write_ignored;
        s_wr_ident ##[1:2] s_rd_ident |=> cfg_rdata == {`BASE_CLASS, `SUB_CLASS,
                                                    programming_interface_code, DESIGN_REV};
    endproperty
    a_ident_write_ignored: assert property (p_ident_write_ignored) else $error("identity changed");

    property p_header_read;
        s_rd_line |=> cfg_rdata[23] && cfg_rdata[22:16] == 7'h00;
    endproperty
    a_header_read: assert property (p_header_read) else $error("header byte wrong");

    property p_cache_line_write;
        cfg_req.sel && cfg_req.wr && cfg_req.dw_idx == `DW_LINE && cfg_req.be[0]
        |=> cache_line_words == $past(cfg_req.wdata[7:0]);
    endproperty
    a_cache_line_write: assert property (p_cache_line_write) else $error("line size not stored");

    property p_cache_line_hold;
        !(cfg_req.sel && cfg_req.wr && cfg_req.dw_idx == `DW_LINE && cfg_req.be[0])
        |=> $stable(cache_line_words);
    endproperty
    a_cache_line_hold: assert property (p_cache_line_hold) else $error("line size moved");

    property p_tenure_write;
        cfg_req.sel && cfg_req.wr && cfg_req.dw_idx == `DW_LINE && cfg_req.be[1]
        ##2 s_rd_line |=> cfg_rdata[15:8] == $past(cfg_req.wdata[15:8], 3);
    endproperty
    a_tenure_write: assert property (p_tenure_write) else $error("timer not stored");

    property p_plain_read;
        cache_line_words == 8'h00 |=> mst_read_cmd == `CMD_MEM_READ;
    endproperty
    a_plain_read: assert property (p_plain_read) else $error("read command wrong");

    property p_wrap_line8;
        tgt_burst_active && cache_line_words == 8'h08 && tgt_dw_addr[2:0] == 3'h7
        |=> burst_wrap;
    endproperty
    a_wrap_line8: assert property (p_wrap_line8) else $error("no wrap at line end");

endmodule

// >>> include/cfg_ident_map.svh
`ifndef CFG_IDENT_MAP_SVH
`define CFG_IDENT_MAP_SVH

// configuration dword indices (byte offset / 4)
`define DW_IDENT        6'h02
`define DW_LINE         6'h03

// byte offsets inside the header
`define OFF_REVISION    8'h08
`define OFF_CLASS       8'h09
`define OFF_CACHE_LINE  8'h0c
`define OFF_TENURE      8'h0d
`define OFF_HEADER      8'h0e

// byte lanes inside the line dword
`define LANE_CACHE_LINE 2'd0
`define LANE_TENURE     2'd1

// fixed identification values
`define BASE_CLASS      8'h0c
`define SUB_CLASS       8'h03
`define PI_OPEN_FS      8'h10
`define PI_ENHANCED_HS  8'h20
`define HEADER_LAYOUT   8'h80
`define SELF_TEST_BYTE  8'h00

// reset values
`define CACHE_LINE_RST  8'h00
`define TENURE_RST      8'h00
`define WORD_ZERO       32'h0000_0000

// memory read commands on the bus
`define CMD_MEM_READ    4'h6
`define CMD_READ_MULT   4'hc
`define CMD_READ_LINE   4'he

`endif

// >>> include/cfg_ident_pkg.sv
package cfg_ident_pkg;

    // one configuration access from the host bridge
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [5:0]  dw_idx;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_s;

    // kind of function this header belongs to
    typedef enum logic [1:0] {
        FN_OPEN_FS_A,
        FN_OPEN_FS_B,
        FN_ENHANCED_HS
    } func_kind_e;

    // whole state of the register slice
    typedef struct packed {
        logic [7:0]  cache_line;
        logic [7:0]  tenure;
        logic        ack;
        logic [31:0] rdata;
        logic [3:0]  rd_cmd;
        logic        wrap;
        logic [7:0]  tenure_left;
        logic        tenure_expired;
        logic        frame_q;
    } regs_s;

endpackage

// >>> src/cache_line_wrap.sv
`timescale 1ns/1ps

// flags the last dword of a cache line; only power-of-two sizes wrap
module cache_line_wrap #(
    parameter int AW = 8
) (
    input  wire logic [7:0]    cache_line_words,
    input  wire logic [AW-1:0] dw_addr,
    output logic               at_line_end
);
    logic [7:0] mask;
    logic       pow2;

    // a size of zero or a non power of two disables wrapping
    always_comb begin
        mask        = cache_line_words - 8'h01;
        pow2        = (cache_line_words != 8'h00) && ((cache_line_words & mask) == 8'h00);
        at_line_end = pow2 && ((dw_addr[7:0] & mask) == mask);
    end
endmodule

// >>> testbench/cfg_host_model.sv
`timescale 1ns/1ps

// host bridge side: issues one configuration access at a time
module cfg_host_model (
    input  wire logic              clk,
    output cfg_ident_pkg::cfg_req_s cfg_req,
    input  wire logic              cfg_ack,
    input  wire logic [31:0]       cfg_rdata
);
    initial cfg_req = '0;

    // one access: request on one edge, answer one cycle later
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ack);
        @(posedge clk);
        cfg_req <= '{sel: 1'b1, wr: wr, dw_idx: idx, be: be, wdata: wd};
        @(posedge clk);
        // idle fields are scrambled so no stale value can pass for a live one
        cfg_req <= '{sel: 1'b0, wr: ~wr, dw_idx: ~idx, be: ~be, wdata: ~wd};
        #1;
        ack = cfg_ack;
        rd  = cfg_rdata;
    endtask
endmodule

// >>> testbench/pci_config_header_ident_regs_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module pci_config_header_ident_regs_bench;
    logic                    clk = 1'b0;
    logic                    sys_rst = 1'b1;
    cfg_ident_pkg::cfg_req_s cfg_req;
    logic                    cfg_ack;
    logic [31:0]             cfg_rdata;
    logic [31:0]             hs_rdata;
    logic [7:0]              cache_line_words;
    logic [7:0]              tenure;
    logic [7:0]              mst_read_dwords = 8'h00;
    logic [3:0]              mst_read_cmd;
    logic                    tgt_burst_active = 1'b0;
    logic [7:0]              tgt_dw_addr = 8'h00;
    logic                    burst_wrap;
    logic                    mst_frame = 1'b0;
    logic                    tenure_expired;
    int                      error_cnt = 0;
    int                      n_compared = 0;
    logic [31:0]             rd;
    logic                    ack;

    // 25 MHz
    always #20 clk = ~clk;

    cfg_host_model cfg_host_model_i (.clk(clk), .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

    cfg_ident_regs cfg_ident_regs_i (
        .clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .cache_line_words(cache_line_words), .bus_master_tenure_count(tenure),
        .mst_read_dwords(mst_read_dwords), .mst_read_cmd(mst_read_cmd),
        .tgt_burst_active(tgt_burst_active), .tgt_dw_addr(tgt_dw_addr), .burst_wrap(burst_wrap),
        .mst_frame(mst_frame), .tenure_expired(tenure_expired));

    // high-speed flavour shares the request, only its read data is looked at
    cfg_ident_regs #(.FUNC_KIND(cfg_ident_pkg::FN_ENHANCED_HS)) cfg_ident_regs_i2 (
        .clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_ack(), .cfg_rdata(hs_rdata),
        .cache_line_words(), .bus_master_tenure_count(), .mst_read_dwords(mst_read_dwords),
        .mst_read_cmd(), .tgt_burst_active(tgt_burst_active), .tgt_dw_addr(tgt_dw_addr),
        .burst_wrap(), .mst_frame(mst_frame), .tenure_expired());

    task automatic report_and_stop();
        $display("compared=%0d errors=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // access plus check of ack and read data
    task automatic acc(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                       input logic [31:0] wd, input logic [31:0] exp);
        cfg_host_model_i.xfer(wr, idx, be, wd, rd, ack);
        `CHK(ack, 1'b1)
        `CHK(rd, exp)
    endtask

    // master and target side inputs, outputs one cycle later
    task automatic side(input logic [7:0] len, input logic act, input logic [7:0] addr,
                        input logic [3:0] cmd, input logic wrap);
        @(posedge clk);
        mst_read_dwords  <= len;
        tgt_burst_active <= act;
        tgt_dw_addr      <= addr;
        @(posedge clk);
        #1;
        `CHK(mst_read_cmd, cmd)
        `CHK(burst_wrap, wrap)
    endtask

    // watchdog: whole sequence needs well under 200 cycles
    initial begin
        #(40 * 2000);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        acc(1'b0, 6'h02, 4'hf, 32'h0, 32'h0c03_1001);
        `CHK(hs_rdata, 32'h0c03_2001)
        acc(1'b0, 6'h03, 4'hf, 32'h0, 32'h0080_0000);
        acc(1'b1, 6'h02, 4'hf, 32'hffff_ffff, 32'h0);
        acc(1'b0, 6'h02, 4'hf, 32'h0, 32'h0c03_1001);
        acc(1'b1, 6'h03, 4'hf, 32'hffff_ffff, 32'h0);
        acc(1'b0, 6'h03, 4'hf, 32'h0, 32'h0080_ffff);
        acc(1'b1, 6'h03, 4'h1, 32'h0000_aa08, 32'h0);
        `CHK(cache_line_words, 8'h08)
        `CHK(tenure, 8'hff)
        acc(1'b0, 6'h3f, 4'hf, 32'h0, 32'h0);
        // read command choice and wrap detect with an 8-dword line
        side(8'h01, 1'b1, 8'h07, 4'h6, 1'b1);
        side(8'h04, 1'b1, 8'h06, 4'he, 1'b0);
        side(8'h09, 1'b0, 8'h07, 4'hc, 1'b0);
        side(8'h08, 1'b1, 8'h0f, 4'he, 1'b1);
        // a 6-dword line is not a power of two, so it never wraps
        acc(1'b1, 6'h03, 4'h1, 32'h0000_0006, 32'h0);
        side(8'h04, 1'b1, 8'h05, 4'he, 1'b0);
        // tenure of 2 clocks: loaded on the edge that sees frame, expired three edges later
        acc(1'b1, 6'h03, 4'h2, 32'h0000_0200, 32'h0);
        @(posedge clk);
        mst_frame <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(tenure_expired, 1'b0)
        @(posedge clk);
        #1;
        `CHK(tenure_expired, 1'b1)
        @(posedge clk);
        mst_frame <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(tenure_expired, 1'b0)
        // bus reset in mid-run clears both writable bytes
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(cache_line_words, 8'h00)
        `CHK(tenure, 8'h00)
        @(posedge clk);
        sys_rst <= 1'b0;
        side(8'h04, 1'b1, 8'h07, 4'h6, 1'b0);
        acc(1'b0, 6'h03, 4'hf, 32'h0, 32'h0080_0000);
        report_and_stop();
    end
endmodule
